/* core/ncpu_core.sv */
`timescale 1ns/100ps
module ncpu_core (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic [2:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   output logic [14:0] rom_addr_out,
   output logic rom_rd_out,
   input wire logic [7:0] rom_data_in,
   output logic [11:0] dm_addr_out,
   output logic dm_rd_out,
   output logic dm_wr_out,
   output logic [3:0] dm_wdata_out,
   input wire logic [3:0] dm_rdata_in,
   output logic retire_out,
   output logic [1:0] retire_cycles_out,
   output logic retire_skip_out
);
   typedef enum logic [3:0] {ST_STOP, ST_FETCH, ST_LAT, ST_DEC, ST_OPND1, ST_OPND2,
                             ST_EXEC, ST_MEMG, ST_TBLG, ST_WAIT} ncpu_state_t;

   ncpu_state_t st, ret_st;
   logic [7:0] op, b1, b2;
   logic [14:0] pc;
   logic [1:0] budget, mc_cnt;
   logic skipping, skip_pend, range_err;
   ncpu_pkg::ncpu_grp_t grp;
   logic [3:0] a, x, h, l, d, e, b, c;
   logic run, system_clock_control, bank_select_enable;
   logic [1:0] cpu_clock_divider_control;
   logic [3:0] bank_select_value;
   logic [7:0] div_cnt;
   logic tick, done, is_skip, range_clr, stopped;
   logic [15:0] abs_de, abs_xa;

   function automatic logic is_xch(input logic [7:0] o);
      is_xch = o == ncpu_pkg::OP_XCH_HL || o == ncpu_pkg::OP_XCH_HLI ||
               o == ncpu_pkg::OP_XCH_HLD || o == ncpu_pkg::OP_XCH_DE ||
               o == ncpu_pkg::OP_XCH_MEM;
   endfunction : is_xch

   function automatic logic [14:0] abs_addr(input logic [15:0] full);
      // out-of-range absolute address is clamped and flagged, never wraps
      abs_addr = (full > {1'b0, ncpu_pkg::TBL_MAX}) ? ncpu_pkg::TBL_MAX : full[14:0];
   endfunction : abs_addr

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   assign stopped = st == ST_STOP;
   assign abs_de = {b, c, d, e};
   assign abs_xa = {b, c, x, a};
   assign is_skip = skip_pend || (grp != ncpu_pkg::NCPU_GRP_NONE &&
                                  ncpu_pkg::op_grp(rom_data_in) == grp);
   assign done = st == ST_WAIT && tick && mc_cnt == 2'(budget - 2'h1);
   assign range_clr = reg_wr_in && reg_addr_in == ncpu_pkg::REG_STAT &&
                      reg_wdata_in[ncpu_pkg::STAT_RANGE];

   // machine cycle divider; tick marks each cpu clock period
   assign tick = div_cnt == 8'h00;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) div_cnt <= 8'h00;
      else if (tick) div_cnt <= 8'(ncpu_pkg::div_sel(cpu_clock_divider_control, system_clock_control) - 8'h01); // RULE5
      else div_cnt <= 8'(div_cnt - 8'h01);
   end

   mc_period_a: assert property (tick |=> !tick [*7]) // RULE5
      else $error("machine cycle shorter than eight clocks");

   // machine cycle budget of the current instruction
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         mc_cnt <= 2'h0;
         retire_out <= 1'b0;
         retire_cycles_out <= 2'h0;
         retire_skip_out <= 1'b0;
      end else begin
         retire_out <= done;
         if (done) begin
            mc_cnt <= 2'h0;
            retire_cycles_out <= budget;
            retire_skip_out <= skipping;
         end else if (tick && !stopped) mc_cnt <= 2'(mc_cnt + 2'h1);
      end
   end

   no_skip_a: assert property (retire_out && !retire_skip_out |->
      retire_cycles_out == ncpu_pkg::op_cycles(op)) // RULE1
      else $error("executed instruction cost differs from its base");
   skip_short_a: assert property (retire_out && retire_skip_out && op != ncpu_pkg::OP_TCALL &&
      ncpu_pkg::op_len(op) != 2'h3 |-> retire_cycles_out == 2'h1) // RULE2
      else $error("short skip not one cycle");
   skip_long_a: assert property (retire_out && retire_skip_out &&
      ncpu_pkg::op_len(op) == 2'h3 |-> retire_cycles_out == 2'h2) // RULE3
      else $error("three-byte skip not two cycles");
   skip_tcall_a: assert property (retire_out && retire_skip_out &&
      op == ncpu_pkg::OP_TCALL |-> retire_cycles_out == 2'h1) // RULE4
      else $error("table-call skip not one cycle");

   // instruction sequencer and memory ports
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         st <= ST_STOP;
         ret_st <= ST_STOP;
         op <= 8'h00;
         b1 <= 8'h00;
         b2 <= 8'h00;
         pc <= ncpu_pkg::PC_RESET;
         budget <= 2'h1;
         skipping <= 1'b0;
         skip_pend <= 1'b0;
         grp <= ncpu_pkg::NCPU_GRP_NONE;
         range_err <= 1'b0;
         rom_addr_out <= ncpu_pkg::PC_RESET;
         rom_rd_out <= 1'b0;
         dm_addr_out <= 12'h000;
         dm_rd_out <= 1'b0;
         dm_wr_out <= 1'b0;
         dm_wdata_out <= 4'h0;
      end else begin
         rom_rd_out <= 1'b0;
         dm_rd_out <= 1'b0;
         dm_wr_out <= 1'b0;
         if (range_clr) range_err <= 1'b0;
         unique case (st)
            ST_STOP: begin
               if (reg_wr_in && reg_addr_in == ncpu_pkg::REG_PC) pc <= reg_wdata_in[14:0];
               if (run && tick) st <= ST_FETCH;
            end
            ST_FETCH: begin
               rom_addr_out <= pc;
               rom_rd_out <= 1'b1;
               pc <= 15'(pc + 15'h1);
               ret_st <= ST_DEC;
               st <= ST_LAT;
            end
            ST_LAT: st <= ret_st;
            ST_DEC: begin
               op <= rom_data_in;
               skipping <= is_skip;
               if (is_skip) begin
                  // fetched only to learn its length; nothing else happens
                  pc <= 15'(pc + 15'(ncpu_pkg::op_len(rom_data_in)) - 15'h1); // RULE17
                  budget <= ncpu_pkg::skip_cost(rom_data_in); // RULE2 RULE3 RULE4 RULE16
                  skip_pend <= 1'b0;
                  st <= ST_WAIT;
               end else begin
                  budget <= ncpu_pkg::op_cycles(rom_data_in); // RULE1
                  grp <= ncpu_pkg::op_grp(rom_data_in); // RULE16
                  if (ncpu_pkg::op_len(rom_data_in) != 2'h1) begin
                     rom_addr_out <= pc;
                     rom_rd_out <= 1'b1;
                     pc <= 15'(pc + 15'h1);
                     ret_st <= ST_OPND1;
                     st <= ST_LAT;
                  end else st <= ST_EXEC;
               end
            end
            ST_OPND1: begin
               b1 <= rom_data_in;
               if (ncpu_pkg::op_len(op) == 2'h3) begin
                  rom_addr_out <= pc;
                  rom_rd_out <= 1'b1;
                  pc <= 15'(pc + 15'h1);
                  ret_st <= ST_OPND2;
                  st <= ST_LAT;
               end else st <= ST_EXEC;
            end
            ST_OPND2: begin
               b2 <= rom_data_in;
               st <= ST_EXEC;
            end
            ST_EXEC: begin
               st <= ST_WAIT;
               ret_st <= ST_MEMG;
               unique case (op)
                  ncpu_pkg::OP_LDA_HL, ncpu_pkg::OP_LDA_HLI, ncpu_pkg::OP_LDA_HLD,
                  ncpu_pkg::OP_XCH_HL, ncpu_pkg::OP_XCH_HLI, ncpu_pkg::OP_XCH_HLD: begin
                     dm_addr_out <= {ncpu_pkg::data_bank(bank_select_enable, bank_select_value, {h, l}), h, l}; // RULE13
                     dm_rd_out <= 1'b1;
                     st <= ST_LAT;
                  end
                  ncpu_pkg::OP_STA_HL: begin
                     dm_addr_out <= {ncpu_pkg::data_bank(bank_select_enable, bank_select_value, {h, l}), h, l};
                     dm_wr_out <= 1'b1;
                     dm_wdata_out <= a;
                  end
                  ncpu_pkg::OP_LDA_DE, ncpu_pkg::OP_XCH_DE: begin
                     dm_addr_out <= {ncpu_pkg::BANK_LOW, d, e}; // RULE12
                     dm_rd_out <= 1'b1;
                     st <= ST_LAT;
                  end
                  ncpu_pkg::OP_LDA_MEM, ncpu_pkg::OP_XCH_MEM: begin
                     dm_addr_out <= {ncpu_pkg::data_bank(bank_select_enable, bank_select_value, b1), b1}; // RULE13
                     dm_rd_out <= 1'b1;
                     st <= ST_LAT;
                  end
                  ncpu_pkg::OP_TBL_PCDE, ncpu_pkg::OP_TBL_PCXA,
                  ncpu_pkg::OP_TBL_BCDE, ncpu_pkg::OP_TBL_BCXA: begin
                     rom_rd_out <= 1'b1;
                     ret_st <= ST_TBLG;
                     st <= ST_LAT;
                     if (op == ncpu_pkg::OP_TBL_PCDE)
                        rom_addr_out <= {pc[14:8], d, e}; // RULE9
                     else if (op == ncpu_pkg::OP_TBL_PCXA)
                        rom_addr_out <= {pc[14:8], x, a}; // RULE10
                     else if (op == ncpu_pkg::OP_TBL_BCDE) begin
                        rom_addr_out <= abs_addr(abs_de); // RULE11 RULE14
                        if (abs_de > {1'b0, ncpu_pkg::TBL_MAX}) range_err <= 1'b1;
                     end else begin
                        rom_addr_out <= abs_addr(abs_xa); // RULE11 RULE14
                        if (abs_xa > {1'b0, ncpu_pkg::TBL_MAX}) range_err <= 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
            ST_MEMG: begin
               if (is_xch(op)) begin
                  // same address as the read; old accumulator goes back out
                  dm_wr_out <= 1'b1; // RULE8
                  dm_wdata_out <= a; // RULE8
               end
               if (op == ncpu_pkg::OP_LDA_HLI || op == ncpu_pkg::OP_XCH_HLI)
                  skip_pend <= l == 4'hf; // RULE6
               if (op == ncpu_pkg::OP_LDA_HLD || op == ncpu_pkg::OP_XCH_HLD)
                  skip_pend <= l == 4'h0; // RULE7
               st <= ST_WAIT;
            end
            ST_TBLG: st <= ST_WAIT;
            ST_WAIT: if (done) st <= run ? ST_FETCH : ST_STOP;
         endcase
      end
   end

   string_skip_a: assert property (st == ST_DEC && grp != ncpu_pkg::NCPU_GRP_NONE &&
      ncpu_pkg::op_grp(rom_data_in) == grp |=> skipping && st == ST_WAIT) // RULE16
      else $error("repeated string load not skipped");
   skip_pc_a: assert property (st == ST_DEC && is_skip |=>
      pc == 15'($past(pc) + 15'(ncpu_pkg::op_len(op)) - 15'h1)) // RULE17
      else $error("skipped instruction length not passed");
   bank_zero_a: assert property (st == ST_EXEC && (op == ncpu_pkg::OP_LDA_DE ||
      op == ncpu_pkg::OP_XCH_DE) |=> dm_rd_out && dm_addr_out[11:8] == ncpu_pkg::BANK_LOW) // RULE12
      else $error("indirect pair access left bank 0");
   bank_sel_a: assert property (st == ST_EXEC && op == ncpu_pkg::OP_LDA_HL |=>
      dm_addr_out[11:8] == (bank_select_enable ? bank_select_value : (h[3] ? ncpu_pkg::BANK_HIGH : ncpu_pkg::BANK_LOW))) // RULE13
      else $error("pointer access in wrong bank");

   sequence tbl_pc_issue_s;
      st == ST_EXEC && op == ncpu_pkg::OP_TBL_PCDE;
   endsequence
   sequence tbl_land_s;
      st == ST_TBLG ##1 st == ST_WAIT;
   endsequence
   tbl_pc_a: assert property (tbl_pc_issue_s |=> rom_rd_out &&
      rom_addr_out == {$past(pc[14:8]), d, e} ##1 tbl_land_s) // RULE9
      else $error("pc-relative table address wrong");
   tbl_abs_a: assert property (st == ST_EXEC && (op == ncpu_pkg::OP_TBL_BCDE ||
      op == ncpu_pkg::OP_TBL_BCXA) |=> rom_addr_out <= ncpu_pkg::TBL_MAX) // RULE14
      else $error("absolute table address out of range");
   tbl_load_a: assert property (st == ST_TBLG |=> {x, a} == $past(rom_data_in)) // RULE10
      else $error("table byte not loaded into wide accumulator");

   sequence swap_issue_s;
      st == ST_EXEC && is_xch(op);
   endsequence
   swap_xchg_a: assert property (swap_issue_s |-> ##3 (dm_wr_out &&
      dm_wdata_out == $past(a, 3) && a == $past(dm_rdata_in))) // RULE8
      else $error("swap did not exchange both nibbles");
   ptr_inc_a: assert property (st == ST_MEMG && op == ncpu_pkg::OP_XCH_HLI |=>
      l == 4'($past(l) + 4'h1) && skip_pend == (l == 4'h0)) // RULE6
      else $error("post-increment wrong");
   ptr_dec_a: assert property (st == ST_MEMG && op == ncpu_pkg::OP_LDA_HLD |=>
      l == 4'($past(l) - 4'h1) && skip_pend == (l == 4'hf)) // RULE7
      else $error("post-decrement wrong");

   // register file
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) {x, a, h, l, b, c, d, e} <= 32'h0;
      else if (stopped) begin
         if (reg_wr_in && reg_addr_in == ncpu_pkg::REG_XAHL) {x, a, h, l} <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == ncpu_pkg::REG_BCDE) {b, c, d, e} <= reg_wdata_in;
      end else if (st == ST_EXEC) begin
         if (op[7:4] == ncpu_pkg::OPH_LDA_N4) a <= op[3:0];
         if (op == ncpu_pkg::OP_LD_XA) {x, a} <= b1;
         if (op == ncpu_pkg::OP_LD_HL) {h, l} <= b1;
         if (op == ncpu_pkg::OP_LD_DE) {d, e} <= b1;
         if (op == ncpu_pkg::OP_LD_BC) {b, c} <= b1;
         if (op == ncpu_pkg::OP_LD_BCDE) {b, c, d, e} <= {b1, b2};
      end else if (st == ST_MEMG) begin
         a <= dm_rdata_in; // RULE8
         if (op == ncpu_pkg::OP_LDA_HLI || op == ncpu_pkg::OP_XCH_HLI)
            l <= 4'(l + 4'h1); // RULE6
         if (op == ncpu_pkg::OP_LDA_HLD || op == ncpu_pkg::OP_XCH_HLD)
            l <= 4'(l - 4'h1); // RULE7
      end else if (st == ST_TBLG) {x, a} <= rom_data_in; // RULE9 RULE10 RULE11
   end

   // software register port
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         run <= 1'b0;
         cpu_clock_divider_control <= 2'h0;
         system_clock_control <= 1'b0;
         bank_select_enable <= 1'b0;
         bank_select_value <= 4'h0;
         reg_rdata_out <= 16'h0000;
      end else begin
         if (reg_wr_in && reg_addr_in == ncpu_pkg::REG_CTRL) begin
            run <= reg_wdata_in[ncpu_pkg::CTRL_RUN];
            cpu_clock_divider_control <= reg_wdata_in[ncpu_pkg::CTRL_PCC +: 2];
            system_clock_control <= reg_wdata_in[ncpu_pkg::CTRL_SCC];
            bank_select_enable <= reg_wdata_in[ncpu_pkg::CTRL_MBE];
            bank_select_value <= reg_wdata_in[ncpu_pkg::CTRL_MBS +: 4];
         end
         reg_rdata_out <= 16'h0000;
         if (reg_rd_in) begin
            unique case (reg_addr_in)
               ncpu_pkg::REG_CTRL: reg_rdata_out <= {7'h0, bank_select_value, bank_select_enable, system_clock_control, cpu_clock_divider_control, run};
               ncpu_pkg::REG_PC: reg_rdata_out <= {1'b0, pc};
               ncpu_pkg::REG_XAHL: reg_rdata_out <= {x, a, h, l};
               ncpu_pkg::REG_BCDE: reg_rdata_out <= {b, c, d, e};
               ncpu_pkg::REG_STAT: reg_rdata_out <= {13'h0, !stopped, skip_pend, range_err};
               default: reg_rdata_out <= 16'h0000;
            endcase
         end
      end
   end
endmodule : ncpu_core

/* pkg/ncpu_pkg.sv */
// Functional notes
// RULE1 - A skip-capable instruction that does not skip costs no extra machine cycles.
// RULE2 - Skipping a one- or two-byte instruction costs exactly one extra machine cycle.
// RULE3 - Skipping a three-byte instruction costs exactly two extra machine cycles.
// RULE4 - Skipping the table-call instruction always costs exactly one machine cycle.
// RULE5 - A machine cycle is one CPU clock period, one of five rates picked by the clock controls.
// RULE6 - Post-increment load/swap use the pointer, then bump L, and skip when L wraps to 0.
// RULE7 - Post-decrement load/swap use the pointer, then drop L, and skip when L wraps to F.
// RULE8 - The swap exchanges accumulator and memory nibble before any pointer adjustment.
// RULE9 - Table read via the second pair fetches ROM at PC bits 14..8 plus that pair, 3 cycles.
// RULE10 - Table read via the wide accumulator uses PC bits 14..8 plus it and replaces it.
// RULE11 - Absolute table reads use the upper pair joined with the second pair or accumulator.
// RULE12 - Accesses through the indirect pair operand always go to bank 0.
// RULE13 - Direct and pointer accesses use the bank value when enabled, else 0 low / 15 high.
// RULE14 - Absolute table addresses stay within 0000 to 7F7F hex.
// RULE15 - Software issues only even addresses for 8-bit transfers with the wide accumulator.
// RULE16 - Back-to-back immediate loads of one string group run the first and skip the rest.
// RULE17 - A skipped instruction is fetched without effect and the PC passes its full length.
package ncpu_pkg;
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_PC = 3'h1;
   localparam logic [2:0] REG_XAHL = 3'h2;
   localparam logic [2:0] REG_BCDE = 3'h3;
   localparam logic [2:0] REG_STAT = 3'h4;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_PCC = 1;
   localparam int CTRL_SCC = 3;
   localparam int CTRL_MBE = 4;
   localparam int CTRL_MBS = 5;
   localparam int STAT_RANGE = 0;
   localparam int STAT_SKIP = 1;
   localparam int STAT_BUSY = 2;
   localparam logic [7:0] DIV_PCC0 = 8'h40;
   localparam logic [7:0] DIV_PCC1 = 8'h20;
   localparam logic [7:0] DIV_PCC2 = 8'h10;
   localparam logic [7:0] DIV_PCC3 = 8'h08;
   localparam logic [7:0] DIV_SUB = 8'h80;
   localparam logic [3:0] BANK_LOW = 4'h0;
   localparam logic [3:0] BANK_HIGH = 4'hf;
   localparam logic [14:0] TBL_MAX = 15'h7f7f;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [3:0] OPH_LDA_N4 = 4'h7;
   localparam logic [7:0] OP_TCALL = 8'h01;
   localparam logic [7:0] OP_LD_XA = 8'h89;
   localparam logic [7:0] OP_LD_HL = 8'h8b;
   localparam logic [7:0] OP_LD_DE = 8'h8c;
   localparam logic [7:0] OP_LD_BC = 8'h8d;
   localparam logic [7:0] OP_LD_BCDE = 8'h8e;
   localparam logic [7:0] OP_LDA_MEM = 8'ha2;
   localparam logic [7:0] OP_XCH_MEM = 8'ha3;
   localparam logic [7:0] OP_TBL_PCDE = 8'hd0;
   localparam logic [7:0] OP_TBL_PCXA = 8'hd1;
   localparam logic [7:0] OP_TBL_BCDE = 8'hd2;
   localparam logic [7:0] OP_TBL_BCXA = 8'hd3;
   localparam logic [7:0] OP_LDA_HL = 8'he0;
   localparam logic [7:0] OP_STA_HL = 8'he1;
   localparam logic [7:0] OP_LDA_HLI = 8'he2;
   localparam logic [7:0] OP_LDA_HLD = 8'he3;
   localparam logic [7:0] OP_LDA_DE = 8'he4;
   localparam logic [7:0] OP_XCH_HL = 8'he8;
   localparam logic [7:0] OP_XCH_HLI = 8'hea;
   localparam logic [7:0] OP_XCH_HLD = 8'heb;
   localparam logic [7:0] OP_XCH_DE = 8'hec;

   typedef enum logic [1:0] {NCPU_GRP_NONE, NCPU_GRP_A, NCPU_GRP_E} ncpu_grp_t;

   function automatic logic [1:0] op_len(input logic [7:0] op);
      unique case (op)
         OP_LD_XA, OP_LD_HL, OP_LD_DE, OP_LD_BC, OP_LDA_MEM, OP_XCH_MEM: op_len = 2'h2;
         OP_LD_BCDE: op_len = 2'h3;
         default: op_len = 2'h1;
      endcase
   endfunction : op_len

   function automatic logic [1:0] op_cycles(input logic [7:0] op);
      unique case (op)
         OP_LD_XA, OP_LD_HL, OP_LD_DE, OP_LD_BC, OP_LDA_MEM, OP_XCH_MEM,
         OP_LDA_HLI, OP_LDA_HLD, OP_XCH_HLI, OP_XCH_HLD: op_cycles = 2'h2;
         OP_LD_BCDE, OP_TBL_PCDE, OP_TBL_PCXA, OP_TBL_BCDE, OP_TBL_BCXA: op_cycles = 2'h3;
         default: op_cycles = 2'h1;
      endcase
   endfunction : op_cycles

   function automatic ncpu_grp_t op_grp(input logic [7:0] op);
      if (op[7:4] == OPH_LDA_N4 || op == OP_LD_XA) op_grp = NCPU_GRP_A;
      else if (op == OP_LD_HL) op_grp = NCPU_GRP_E;
      else op_grp = NCPU_GRP_NONE;
   endfunction : op_grp

   function automatic logic [1:0] skip_cost(input logic [7:0] op);
      if (op == OP_TCALL) skip_cost = 2'h1;
      else if (op_len(op) == 2'h3) skip_cost = 2'h2;
      else skip_cost = 2'h1;
   endfunction : skip_cost

   function automatic logic [7:0] div_sel(input logic [1:0] cpu_clock_divider_control, input logic system_clock_control);
      if (system_clock_control) div_sel = DIV_SUB;
      else begin
         unique case (cpu_clock_divider_control)
            2'h0: div_sel = DIV_PCC0;
            2'h1: div_sel = DIV_PCC1;
            2'h2: div_sel = DIV_PCC2;
            2'h3: div_sel = DIV_PCC3;
         endcase
      end
   endfunction : div_sel

   function automatic logic [3:0] data_bank(input logic bank_select_enable, input logic [3:0] bank_select_value,
                                            input logic [7:0] addr);
      if (bank_select_enable) data_bank = bank_select_value;
      else data_bank = addr[7] ? BANK_HIGH : BANK_LOW;
   endfunction : data_bank
endpackage : ncpu_pkg

/* tb/ncpu_mem_model.sv */
`timescale 1ns/100ps
module ncpu_mem_model (
   input wire logic clk_in,
   input wire logic [14:0] rom_addr_in,
   input wire logic rom_rd_in,
   output logic [7:0] rom_data_out,
   input wire logic [11:0] dm_addr_in,
   input wire logic dm_rd_in,
   input wire logic dm_wr_in,
   input wire logic [3:0] dm_wdata_in,
   output logic [3:0] dm_rdata_out
);
   logic [7:0] prog [0:15];
   logic [3:0] dmem [0:4095];
   logic [7:0] rom_q = 8'h00;
   logic [3:0] dm_q = 4'h0;
   logic rom_v = 1'b0;
   logic dm_v = 1'b0;
   // nibble store only: no 8-bit transfers reach it
   initial begin
      for (int i = 0; i < 4096; i++) begin
         dmem[i] = i[3:0] ^ i[7:4];
      end
   end
   always @(posedge clk_in) begin
      rom_v <= rom_rd_in;
      dm_v <= dm_rd_in;
      if (rom_rd_in) begin
         rom_q <= (rom_addr_in < 15'h0010) ? prog[rom_addr_in[3:0]] : rom_addr_in[7:0] ^ 8'h5a;
      end
      if (dm_rd_in) begin
         dm_q <= dmem[dm_addr_in];
      end
      if (dm_wr_in) begin
         dmem[dm_addr_in] <= dm_wdata_in;
      end
   end
   // outside the data cycle the lines show garbage, never the last value
   assign rom_data_out = rom_v ? rom_q : ~rom_q;
   assign dm_rdata_out = dm_v ? dm_q : ~dm_q;
endmodule : ncpu_mem_model

/* tb/nibble_cpu_transfer_and_skip_timing_bench.sv */
`timescale 1ns/100ps
module nibble_cpu_transfer_and_skip_timing_bench;
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [2:0] reg_addr_in = 3'h0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [15:0] reg_rdata_out;
   logic [14:0] rom_addr_out;
   logic rom_rd_out;
   logic [7:0] rom_data_in;
   logic [11:0] dm_addr_out;
   logic dm_rd_out;
   logic dm_wr_out;
   logic [3:0] dm_wdata_out;
   logic [3:0] dm_rdata_in;
   logic retire_out;
   logic [1:0] retire_cycles_out;
   logic retire_skip_out;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int last_ret = 0;
   int nret = 0;
   int div = 8;
   int e;
   bit first = 1'b1;
   int ret_q[$];
   int dm_q[$];
   logic [3:0] exp_wd;
   logic [7:0] rnd = 8'h44;
   logic [7:0] de;
   logic [15:0] v;
   always #2.5 clk_sys_in = ~clk_sys_in;
   ncpu_core dut (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .rom_addr_out, .rom_rd_out, .rom_data_in, .dm_addr_out, .dm_rd_out,
      .dm_wr_out, .dm_wdata_out, .dm_rdata_in, .retire_out, .retire_cycles_out, .retire_skip_out);
   ncpu_mem_model mem (.clk_in(clk_sys_in), .rom_addr_in(rom_addr_out), .rom_rd_in(rom_rd_out),
      .rom_data_out(rom_data_in), .dm_addr_in(dm_addr_out), .dm_rd_in(dm_rd_out),
      .dm_wr_in(dm_wr_out), .dm_wdata_in(dm_wdata_out), .dm_rdata_out(dm_rdata_in));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      d = reg_rdata_out;
      @(posedge clk_sys_in);
   endtask : rd
   task automatic wait_ret(input int n);
      for (int i = 0; i < 3000 && nret < n; i++) begin
         @(posedge clk_sys_in);
      end
      if (nret < n) begin
         miscompares++;
         close_out();
      end
   endtask : wait_ret
   task automatic wait_idle();
      // a table read on the slowest clock outlasts many polls
      for (int i = 0; i < 200; i++) begin
         rd(ncpu_pkg::REG_STAT, v);
         if (v[ncpu_pkg::STAT_BUSY] === 1'b0) return;
      end
      miscompares++;
      close_out();
   endtask : wait_idle
   always @(negedge clk_sys_in) begin
      cyc++;
      if (retire_out === 1'b1) begin
         nret++;
         if (ret_q.size() > 0) begin
            e = ret_q.pop_front();
            chk("retire", {13'h0, retire_cycles_out, retire_skip_out}, 16'(e));
            if (!first) chk("spacing", 16'(cyc - last_ret), 16'((e >> 1) * div));
            first = 1'b0;
            last_ret = cyc;
         end
      end
      if (dm_rd_out === 1'b1 || dm_wr_out === 1'b1) begin
         e = (dm_q.size() == 0) ? -1 : dm_q.pop_front();
         chk("dm access", {3'h0, dm_wr_out, dm_addr_out}, 16'(e));
         if (dm_wr_out === 1'b1) chk("dm wdata", {12'h0, dm_wdata_out}, {12'h0, exp_wd});
      end
   end
   initial begin
      // nibble programs only, no 8-bit data transfers
      mem.prog = '{8'h70, 8'h89, 8'h33, 8'he8, 8'he2, 8'h8e, 8'h11, 8'h22,
                   8'he3, 8'h01, 8'hd0, 8'hd1, 8'he4, 8'h00, 8'hd2, 8'hd3};
      repeat (3) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      @(posedge clk_sys_in);
      for (int i = 0; i < 8; i++) begin
         rd(3'(i), v);
         chk("reset value", v, 16'h0000);
      end
      rnd = lfsr(rnd);
      mem.prog[0] = {4'h7, rnd[3:0]};
      exp_wd = rnd[3:0];
      rnd = lfsr(rnd);
      de = {1'b1, rnd[6:0]};
      rnd = lfsr(rnd);
      wr(ncpu_pkg::REG_XAHL, {rnd, 8'h8f});
      wr(ncpu_pkg::REG_BCDE, {8'h00, de});
      ret_q = '{2, 3, 2, 4, 5, 4, 3, 6, 6, 2};
      dm_q = '{'h0f8f, 'h1f8f, 'h0f8f, 'h0f80, int'(de)};
      wr(ncpu_pkg::REG_CTRL, 16'h0007);
      wait_ret(10);
      wr(ncpu_pkg::REG_CTRL, 16'h0006);
      wait_idle();
      rd(ncpu_pkg::REG_XAHL, v);
      chk("xahl run1", v, {de[7:4], de[3:0] ^ de[7:4], 8'h8f});
      wr(ncpu_pkg::REG_PC, 16'h000e);
      wr(ncpu_pkg::REG_BCDE, {8'h7f, de});
      div = 16;
      first = 1'b1;
      ret_q = '{6, 6};
      wr(ncpu_pkg::REG_CTRL, 16'h0005);
      wait_ret(nret + 2);
      wr(ncpu_pkg::REG_CTRL, 16'h0004);
      wait_idle();
      rd(ncpu_pkg::REG_XAHL, v);
      chk("xahl run2", v, 16'h7f8f);
      rd(ncpu_pkg::REG_STAT, v);
      chk("range flag", {15'h0, v[ncpu_pkg::STAT_RANGE]}, 16'h0001);
      wr(ncpu_pkg::REG_STAT, 16'h0001);
      rd(ncpu_pkg::REG_STAT, v);
      chk("range clear", {15'h0, v[ncpu_pkg::STAT_RANGE]}, 16'h0000);
      // banked pointer load on the subclock, then an out-of-range absolute read
      mem.prog[13] = ncpu_pkg::OP_LDA_HL;
      wr(ncpu_pkg::REG_PC, 16'h000d);
      div = 128;
      first = 1'b1;
      ret_q = '{2, 6};
      dm_q = '{'h028f};
      wr(ncpu_pkg::REG_CTRL, 16'h0059);
      wait_ret(nret + 2);
      wr(ncpu_pkg::REG_CTRL, 16'h0058);
      wait_idle();
      chk("dm left", 16'(dm_q.size()), 16'h0000);
      rd(ncpu_pkg::REG_XAHL, v);
      chk("xahl run3", v, 16'h7f8f);
      rd(ncpu_pkg::REG_STAT, v);
      chk("range again", {15'h0, v[ncpu_pkg::STAT_RANGE]}, 16'h0001);
      close_out();
   end
endmodule : nibble_cpu_transfer_and_skip_timing_bench
